// >>> hdl/host_psram_end.sv
`timescale 1ns/100ps
`default_nettype none
// host end: makes the link clock from ref_clk by a divider
module host_psram_end
    import psram_link_pkg::*;
#(
    parameter int DIV = CLK_DIV,
    parameter int LAT = LAT_EDGES
) (
    input wire logic ref_clk,
    input wire logic rst,
    psram_link_if.host link,
    input wire logic diff_clock,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_read,
    input wire logic [7:0] req_addr,
    input wire logic [7:0] req_len,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [7:0] wr_data,
    input wire logic wr_mask,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [7:0] rd_data
);
    localparam int DW = $clog2(DIV) + 1;
    localparam logic [DW-1:0] DIV_M1 = DW'(DIV - 1);
    localparam logic [7:0] CA_N = 8'(CA_BYTES);
    localparam logic [7:0] CA_LAST = 8'(CA_BYTES - 1);
    localparam logic [7:0] DATA1 = 8'(CA_BYTES + LAT);
    localparam logic [7:0] DATA2 = 8'(CA_BYTES + 2 * LAT);

    typedef struct packed {
        host_state_t st;
        logic [DW-1:0] div;
        logic ck;
        logic ckc;
        logic cs_n;
        logic pin_rst_n;
        logic [7:0] dq_o;
        logic dq_oe;
        logic sml_o;
        logic sml_oe;
        logic [7:0] edg;
        logic [7:0] left;
        logic [7:0] addr;
        logic rd;
        logic xlat;
        logic have;
        logic rx0;
        logic [7:0] dq_s1;
        logic [7:0] dq_s2;
        logic sml_s1;
        logic sml_s2;
    } host_regs_t;

    host_regs_t r_ff;
    host_regs_t nxt_r;
    logic tick;
    logic push;
    logic buf_ready;
    logic cap;
    logic [7:0] data_edge;

    if (DIV < 2 || LAT < 1 || CA_BYTES + 2 * LAT > 250)
    begin : g_chk
        $error("host_psram_end: DIV or LAT out of range");
    end

    function automatic logic [7:0] ca_byte(input logic [7:0] k,
        input logic rd, input logic [7:0] a);
        ca_byte = IDLE_BYTE;
        if (k == 8'h00)
            ca_byte = CA_FIRST | (rd ? CA_READ : IDLE_BYTE);
        else if (k == CA_LAST)
            ca_byte = a;
    endfunction

    // one select per attached device, this end serves one
    assign link.cs_n = r_ff.cs_n;
    assign link.clock_true = r_ff.ck;
    assign link.clock_complement = r_ff.ckc;
    assign link.reset_n = r_ff.pin_rst_n;
    assign link.dq_h_o = r_ff.dq_o;
    assign link.dq_h_oe = r_ff.dq_oe;
    assign link.sml_h_o = r_ff.sml_o;
    assign link.sml_h_oe = r_ff.sml_oe;

    assign tick = r_ff.div == DIV_M1;
    assign data_edge = r_ff.xlat ? DATA2 : DATA1;
    // a read byte is new when the strobe reached the next level
    assign cap = r_ff.rd && r_ff.st == M_DATA && r_ff.edg >= CA_N
        && r_ff.sml_s2 == !r_ff.rx0 && r_ff.left != 8'h00;

    always_comb
    begin
        nxt_r = r_ff;
        push = 1'b0;
        req_ready = 1'b0;
        wr_ready = 1'b0;
        nxt_r.pin_rst_n = 1'b1;
        nxt_r.dq_s1 = link.dq;
        nxt_r.dq_s2 = r_ff.dq_s1;
        nxt_r.sml_s1 = link.strobe_mask_line;
        nxt_r.sml_s2 = r_ff.sml_s1;
        nxt_r.div = tick ? '0 : r_ff.div + DW'(1);
        unique case (r_ff.st)
            M_IDLE:
            begin
                nxt_r.div = '0;
                nxt_r.ckc = diff_clock;
                req_ready = 1'b1;
                if (req_valid)
                begin
                    // clock stays idle low as select falls
                    nxt_r.cs_n = 1'b0;
                    nxt_r.rd = req_read;
                    nxt_r.addr = req_addr;
                    nxt_r.left = req_len;
                    nxt_r.edg = 8'h00;
                    nxt_r.have = 1'b0;
                    nxt_r.rx0 = 1'b0;
                    nxt_r.dq_o = ca_byte(8'h00, req_read, req_addr);
                    nxt_r.dq_oe = 1'b1;
                    nxt_r.st = M_CA;
                end
            end
            M_CA, M_DATA:
            begin
                // write byte set up in the low phase, away from a rise
                if (r_ff.st == M_DATA && !r_ff.rd && !r_ff.ck && !tick
                    && !r_ff.have && r_ff.left != 8'h00)
                begin
                    wr_ready = 1'b1;
                    if (wr_valid)
                    begin
                        nxt_r.dq_o = wr_data;
                        nxt_r.sml_o = wr_mask;
                        nxt_r.have = 1'b1;
                    end
                end
                if (r_ff.st == M_DATA && !r_ff.ck && r_ff.left == 8'h00)
                begin
                    // frame over: select rises with the clock low
                    nxt_r.cs_n = 1'b1;
                    nxt_r.dq_oe = 1'b0;
                    nxt_r.sml_oe = 1'b0;
                    nxt_r.st = M_IDLE;
                end
                else if (tick && r_ff.ck)
                begin
                    nxt_r.ck = 1'b0;
                    nxt_r.ckc = diff_clock;
                    if (r_ff.st == M_CA)
                        nxt_r.dq_o = ca_byte(r_ff.edg, r_ff.rd, r_ff.addr);
                    else
                    begin
                        // device released the line; writes take it over
                        nxt_r.dq_oe = !r_ff.rd;
                        nxt_r.sml_oe = !r_ff.rd;
                    end
                end
                else if (tick && !(cap && !buf_ready)
                    && !(!r_ff.rd && r_ff.st == M_DATA
                    && r_ff.edg >= data_edge && !r_ff.have))
                begin
                    // stall: clock held low until data can move
                    if (cap)
                    begin
                        push = 1'b1;
                        nxt_r.rx0 = !r_ff.rx0;
                        nxt_r.left = r_ff.left - 8'h01;
                    end
                    if (!cap || r_ff.left != 8'h01)
                    begin
                        nxt_r.ck = 1'b1;
                        nxt_r.ckc = 1'b0;
                        nxt_r.edg = (r_ff.edg == EDGE_MAX) ? r_ff.edg
                            : r_ff.edg + 8'h01;
                        if (r_ff.st == M_CA && r_ff.edg == CA_LAST)
                        begin
                            nxt_r.xlat = r_ff.sml_s2;
                            nxt_r.st = M_DATA;
                        end
                        if (!r_ff.rd && r_ff.st == M_DATA
                            && r_ff.edg >= data_edge)
                        begin
                            nxt_r.have = 1'b0;
                            nxt_r.left = r_ff.left - 8'h01;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            r_ff <= '0;
            r_ff.st <= M_IDLE;
            r_ff.cs_n <= 1'b1;
        end
        else
            r_ff <= nxt_r;
    end

    // read bytes wait here when the user stalls
    two_entry_buf #(
        .WIDTH(8)
    ) u_rd_buf (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(push),
        .in_ready(buf_ready),
        .in_data(r_ff.dq_s2),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );
endmodule
`default_nettype wire

// >>> hdl/psram_link_pkg.sv
`default_nettype none
package psram_link_pkg;
    localparam int CA_BYTES = 6;
    localparam int CA_RW_BIT = 7;
    localparam logic [7:0] CA_FIRST = 8'h20;
    localparam logic [7:0] CA_READ = 8'h80;
    localparam int LAT_EDGES = 3;
    localparam int CLK_DIV = 4;
    localparam int MEM_BYTES = 32;
    localparam logic [7:0] EDGE_MAX = 8'hff;
    localparam logic [7:0] IDLE_BYTE = 8'h00;

    typedef enum logic [2:0] {
        M_IDLE = 3'b001,
        M_CA = 3'b010,
        M_DATA = 3'b100
    } host_state_t;

    typedef enum logic [3:0] {
        D_CA = 4'b0001,
        D_LAT = 4'b0010,
        D_RD = 4'b0100,
        D_WR = 4'b1000
    } dev_state_t;
endpackage
`default_nettype wire

// >>> hdl/psram_link_if.sv
`timescale 1ns/100ps
`default_nettype none
// shared pins; the wire level is resolved here from the output enables
interface psram_link_if;
    import psram_link_pkg::*;
    logic cs_n;
    logic clock_true;
    logic clock_complement;
    logic reset_n;
    logic [7:0] dq_h_o;
    logic dq_h_oe;
    logic [7:0] dq_d_o;
    logic dq_d_oe;
    logic [7:0] dq;
    logic sml_h_o;
    logic sml_h_oe;
    logic sml_d_o;
    logic sml_d_oe;
    logic strobe_mask_line;

    // undriven lanes read as idle
    assign dq = dq_d_oe ? dq_d_o : (dq_h_oe ? dq_h_o : IDLE_BYTE);
    assign strobe_mask_line = sml_d_oe ? sml_d_o : (sml_h_oe ? sml_h_o : 1'b0);

    modport host (
        output cs_n, clock_true, clock_complement, reset_n,
        output dq_h_o, dq_h_oe, sml_h_o, sml_h_oe,
        input dq, strobe_mask_line
    );
    modport device (
        input cs_n, clock_true, clock_complement, reset_n,
        input dq, strobe_mask_line,
        output dq_d_o, dq_d_oe, sml_d_o, sml_d_oe
    );
endinterface
`default_nettype wire

// >>> hdl/two_entry_buf.sv
`timescale 1ns/100ps
`default_nettype none
module two_entry_buf #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] slot;
        logic [1:0] fill;
        logic head;
    } buf_regs_t;

    buf_regs_t r_ff;
    buf_regs_t nxt_r;
    logic push;
    logic pop;

    if (WIDTH < 1)
    begin : g_chk
        $error("two_entry_buf: WIDTH must be positive");
    end

    // handshakes straight from occupancy
    assign in_ready = r_ff.fill != 2'd2;
    assign out_valid = r_ff.fill != 2'd0;
    assign out_data = r_ff.slot[r_ff.head];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // write at tail, read at head; fill moves by push minus pop
    always_comb
    begin
        nxt_r = r_ff;
        if (push)
            nxt_r.slot[r_ff.head ^ r_ff.fill[0]] = in_data;
        if (pop)
            nxt_r.head = ~r_ff.head;
        if (push && !pop)
            nxt_r.fill = r_ff.fill + 2'd1;
        else if (pop && !push)
            nxt_r.fill = r_ff.fill - 2'd1;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            r_ff <= '0;
        else
            r_ff <= nxt_r;
    end
endmodule
`default_nettype wire

// >>> hdl/dev_psram_end.sv
`timescale 1ns/100ps
`default_nettype none
// device end: runs entirely on the link's true clock
module dev_psram_end
    import psram_link_pkg::*;
#(
    parameter int LAT = LAT_EDGES,
    parameter int MEM = MEM_BYTES
) (
    psram_link_if.device link,
    input wire logic rst,
    input wire logic extra_latency
);
    localparam int AW = $clog2(MEM);
    localparam logic [7:0] CA_LAST = 8'(CA_BYTES - 1);
    localparam logic [7:0] LAT1_M1 = 8'(LAT - 1);
    localparam logic [7:0] LAT2_M1 = 8'(2 * LAT - 1);

    typedef struct packed {
        logic sync1;
        logic sync2;
        dev_state_t st;
        logic [7:0] cnt;
        logic rd;
        logic xlat;
        logic [AW-1:0] addr;
        logic [7:0] dq_o;
        logic dq_oe;
        logic sml_o;
        logic sml_oe;
    } dev_regs_t;

    dev_regs_t r_ff;
    dev_regs_t nxt_r;
    logic [7:0] mem [MEM];
    logic clr;
    logic we;
    logic [7:0] lat_end;
    logic [7:0] rd_byte;

    if (LAT < 1 || CA_BYTES + 2 * LAT > 250)
    begin : g_chk_lat
        $error("dev_psram_end: LAT out of range");
    end
    if (MEM < 4 || MEM > 512 || (1 << AW) != MEM)
    begin : g_chk_mem
        $error("dev_psram_end: MEM must be a power of two, 4..512");
    end

    // deselect or pin reset clears the frame at once, no clock needed;
    // the host may stop the clock the moment select rises
    assign clr = rst || !link.reset_n || link.cs_n;

    // outputs come straight from flops that clr forces off
    assign link.dq_d_o = r_ff.dq_o;
    assign link.dq_d_oe = r_ff.dq_oe;
    assign link.sml_d_o = r_ff.sml_o;
    assign link.sml_d_oe = r_ff.sml_oe;

    // latency length chosen by what we showed during the command phase
    assign lat_end = r_ff.xlat ? LAT2_M1 : LAT1_M1;
    assign rd_byte = mem[r_ff.addr];

    // frame sequencer; cleared state is the first command byte
    always_comb
    begin
        nxt_r = r_ff;
        we = 1'b0;
        nxt_r.sync1 = extra_latency;
        nxt_r.sync2 = r_ff.sync1;
        unique case (r_ff.st)
            D_CA:
            begin
                // flag refresh latency while the command bytes arrive
                nxt_r.sml_oe = 1'b1;
                nxt_r.sml_o = r_ff.sync2;
                nxt_r.cnt = r_ff.cnt + 8'h01;
                if (r_ff.cnt == 8'h00)
                    nxt_r.rd = link.dq[CA_RW_BIT];
                if (r_ff.cnt == CA_LAST)
                begin
                    // last command byte is the low word address
                    nxt_r.addr = {link.dq[AW-2:0], 1'b0};
                    nxt_r.xlat = r_ff.sml_o;
                    nxt_r.sml_o = 1'b0;
                    // writes hand the line to the host as a mask
                    nxt_r.sml_oe = r_ff.rd;
                    nxt_r.cnt = 8'h00;
                    nxt_r.st = D_LAT;
                end
            end
            D_LAT:
            begin
                nxt_r.cnt = r_ff.cnt + 8'h01;
                if (r_ff.cnt == lat_end)
                begin
                    if (r_ff.rd)
                    begin
                        // first read byte with the first strobe edge
                        nxt_r.dq_o = rd_byte;
                        nxt_r.dq_oe = 1'b1;
                        nxt_r.sml_o = ~r_ff.sml_o;
                        nxt_r.addr = r_ff.addr + AW'(1);
                        nxt_r.st = D_RD;
                    end
                    else
                        nxt_r.st = D_WR;
                end
            end
            D_RD:
            begin
                // one byte per edge, strobe toggles with it
                nxt_r.dq_o = rd_byte;
                nxt_r.sml_o = ~r_ff.sml_o;
                nxt_r.addr = r_ff.addr + AW'(1);
            end
            D_WR:
            begin
                // masked bytes leave memory untouched
                we = !link.strobe_mask_line;
                nxt_r.addr = r_ff.addr + AW'(1);
            end
        endcase
    end

    // single-ended timing: complement clock is never looked at
    always_ff @(posedge link.clock_true or posedge clr)
    begin
        if (clr)
        begin
            r_ff <= '0;
            r_ff.st <= D_CA;
        end
        else
            r_ff <= nxt_r;
    end

    // storage survives deselect and pin reset
    always_ff @(posedge link.clock_true)
    begin
        if (we)
            mem[r_ff.addr] <= link.dq;
    end
endmodule
`default_nettype wire

// >>> testbench/psram_link_props.sv
`timescale 1ns/100ps
`default_nettype none
// pin checks; host pins on ref_clk, read strobe on the link clock
module psram_link_props (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic diff_clock,
    input wire logic cs_n,
    input wire logic clock_true,
    input wire logic clock_complement,
    input wire logic reset_n,
    input wire logic [7:0] dq_h_o,
    input wire logic dq_h_oe,
    input wire logic dq_d_oe,
    input wire logic sml_d_o,
    input wire logic sml_d_oe
);
    // pin reset low must leave lanes and strobe undriven
    a_reset_quiet: assert property (
        @(posedge ref_clk) disable iff (rst)
        !reset_n |-> !dq_d_oe && !sml_d_oe)
        else $error("device drives pins in pin reset");
    a_deselect_quiet: assert property (
        @(posedge ref_clk) disable iff (rst)
        cs_n |-> !dq_d_oe && !sml_d_oe)
        else $error("deselected device drives pins");
    // a frame opens with the clock pair at rest
    a_start_idle: assert property (
        @(posedge ref_clk) disable iff (rst)
        $fell(cs_n) |-> !clock_true && clock_complement == diff_clock)
        else $error("clock not idle at select");
    a_ca_marker: assert property (
        @(posedge ref_clk) disable iff (rst)
        $fell(cs_n) |-> dq_h_oe && (dq_h_o & 8'h7f) == 8'h20)
        else $error("first command byte missing");
    a_diff_pair: assert property (
        @(posedge ref_clk) disable iff (rst)
        !cs_n && diff_clock && $past(diff_clock)
        |-> clock_complement != clock_true)
        else $error("complement clock not inverse");
    a_single_end: assert property (
        @(posedge ref_clk) disable iff (rst)
        !diff_clock && !$past(diff_clock) |-> !clock_complement)
        else $error("complement clock moves single ended");
    a_one_driver: assert property (
        @(posedge ref_clk) disable iff (rst)
        !(dq_h_oe && dq_d_oe))
        else $error("both ends drive the lanes");
    // the link clock may stop, and must stop, between frames
    a_idle_still: assert property (
        @(posedge ref_clk) disable iff (rst)
        cs_n && $past(cs_n) |-> $stable(clock_true))
        else $error("link clock runs while idle");
    a_strobe_toggle: assert property (
        @(posedge clock_true) disable iff (rst)
        dq_d_oe && $past(dq_d_oe) && sml_d_oe
        |-> sml_d_o != $past(sml_d_o))
        else $error("read strobe did not toggle");
    c_diff_frame: cover property (
        @(posedge ref_clk) $fell(cs_n) && diff_clock);
    c_read_data: cover property (
        @(posedge ref_clk) dq_d_oe && sml_d_oe);
    c_frame_end: cover property (
        @(posedge ref_clk) $rose(cs_n) && !rst);
endmodule
`default_nettype wire

// >>> testbench/test_ddr_psram_bus_pin_behaviour.sv
`timescale 1ns/100ps
`default_nettype none
// bench drives the host user side; the device sits across the link
module test_ddr_psram_bus_pin_behaviour;
    import psram_link_pkg::*;
    localparam int LAT_T = 3;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic diff_clock = 1'b0;
    logic extra_latency = 1'b0;
    logic req_valid = 1'b0;
    logic req_ready;
    logic req_read = 1'b0;
    logic [7:0] req_addr = 8'h00;
    logic [7:0] req_len = 8'h01;
    logic wr_valid = 1'b0;
    logic wr_ready;
    logic [7:0] wr_data = 8'h00;
    logic wr_mask = 1'b0;
    logic rd_valid;
    logic rd_ready = 1'b0;
    logic [7:0] rd_data;
    logic ct_prev = 1'b0;
    integer seed = 32'hac4a;
    int err_total = 0;
    int checked = 0;
    int edges = 0;
    int r;
    int i;
    int a;
    logic [7:0] mem [32];
    logic [7:0] rd_q [$];
    logic [15:0] ca_q [$];
    int edge_q [$];

    psram_link_if link ();
    host_psram_end #(.DIV(4), .LAT(LAT_T)) host_psram_end_i (
        .ref_clk, .rst, .link(link), .diff_clock, .req_valid,
        .req_ready, .req_read, .req_addr, .req_len, .wr_valid,
        .wr_ready, .wr_data, .wr_mask, .rd_valid, .rd_ready, .rd_data
    );
    dev_psram_end #(.LAT(LAT_T), .MEM(32)) dev_psram_end_i (
        .link(link), .rst, .extra_latency
    );
    psram_link_props psram_link_props_i (
        .ref_clk, .rst, .diff_clock, .cs_n(link.cs_n),
        .clock_true(link.clock_true),
        .clock_complement(link.clock_complement),
        .reset_n(link.reset_n), .dq_h_o(link.dq_h_o),
        .dq_h_oe(link.dq_h_oe), .dq_d_oe(link.dq_d_oe),
        .sml_d_o(link.sml_d_o), .sml_d_oe(link.sml_d_oe)
    );

    always #2.5 ref_clk = ~ref_clk;

    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask

    // ready is combinational, so it is read at the falling edge
    task automatic take(input bit w);
        int t;
        t = 0;
        do
        begin
            @(negedge ref_clk);
            t++;
        end
        while ((w ? wr_ready : req_ready) !== 1'b1 && t < 3000);
        check("ready", {15'h0000, w ? wr_ready : req_ready}, 16'h0001);
        tick();
    endtask

    // one frame; expected bytes and counts are noted before it runs
    task automatic xfer(input logic rd, input int wa, input int n,
        input logic ex, input logic dc, input logic msk);
        int k;
        int t;
        logic m;
        diff_clock = dc;
        extra_latency = ex;
        tick();
        req_valid = 1'b1;
        req_read = rd;
        req_addr = 8'(wa);
        req_len = 8'(n);
        // a read stops the clock once its last byte has been taken
        edge_q.push_back(5 + (ex ? 2 * LAT_T : LAT_T) + n + int'(!rd));
        ca_q.push_back({rd, 7'h20, 8'(wa)});
        for (k = 0; k < n && rd; k++)
            rd_q.push_back(mem[2 * wa + k]);
        take(1'b0);
        req_valid = 1'b0;
        for (k = 0; k < n && !rd; k++)
        begin
            m = msk & 1'($random(seed));
            wr_valid = 1'b1;
            wr_data = 8'($random(seed));
            wr_mask = m;
            if (!m)
                mem[2 * wa + k] = wr_data;
            take(1'b1);
        end
        wr_valid = 1'b0;
        t = 0;
        while (link.cs_n !== 1'b1 && t < 3000)
        begin
            @(negedge ref_clk);
            t++;
        end
        check("frame_end", {15'h0000, link.cs_n}, 16'h0001);
        tick();
    endtask

    // reader stalls about one cycle in four
    always @(posedge ref_clk)
        rd_ready <= #1 ($random(seed) % 4 != 0);

    // read bytes leaving the buffer against the oldest note
    always @(posedge ref_clk)
    begin
        if (rd_valid === 1'b1 && rd_ready === 1'b1)
        begin
            if (rd_q.size() == 0)
                check("rd_extra", 16'h0001, 16'h0000);
            else
                check("rd_data", {8'h00, rd_data}, rd_q.pop_front());
        end
    end

    // wire view: rises of the link clock counted per frame
    always @(negedge ref_clk)
    begin
        if (link.cs_n === 1'b0 && link.clock_true === 1'b1 && !ct_prev)
        begin
            if (edges == 0 && ca_q.size() > 0)
                check("ca0", {8'h00, link.dq}, ca_q[0] >> 8);
            if (edges == 5 && ca_q.size() > 0)
                check("ca5", {8'h00, link.dq}, ca_q[0] & 16'h00ff);
            edges++;
        end
        if (link.cs_n === 1'b1 && edges != 0)
        begin
            if (edge_q.size() > 0)
                check("edges", 16'(edges), 16'(edge_q.pop_front()));
            if (ca_q.size() > 0)
                void'(ca_q.pop_front());
            edges = 0;
        end
        ct_prev = link.clock_true;
    end

    // second round resets in mid-run after traffic
    initial
    begin
        for (r = 0; r < 2; r++)
        begin
            rst = 1'b1;
            repeat (12) @(posedge ref_clk);
            #1;
            rst = 1'b0;
            xfer(1'b0, 0, 32, 1'b0, 1'b0, 1'b0);
            for (i = 0; i < 14; i++)
            begin
                a = int'($unsigned($random(seed)) % 16);
                xfer(1'($random(seed)), a,
                    1 + int'($unsigned($random(seed)) % (32 - 2 * a)),
                    1'($random(seed)), 1'($random(seed)), 1'b1);
            end
            xfer(1'b1, 0, 32, 1'b1, 1'b1, 1'b0);
            i = 0;
            while (rd_q.size() != 0 && i < 3000)
            begin
                tick();
                i++;
            end
            check("rd_left", 16'(rd_q.size()), 16'h0000);
        end
        wrap_up();
    end

    // hang guard, well past the expected run length
    initial
    begin
        #300000;
        err_total++;
        wrap_up();
    end
endmodule
`default_nettype wire
